// file: test/idx_decode_tb.sv
// Purpose: self-checking bench for the indexed offset operand decoder
// Assumes: data memory modelled by mem_rdata; wishbone classic master tasks
// Notes:   expected values worked out by hand from the rules
`timescale 1ns/1ns
`default_nettype none
module idx_decode_tb;
    import idx_decode_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    instr_s instr = '0;
    mem_req_s mem_o;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_we = 1'b0;
    logic [3:0] wb_sel = 4'h0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_ack_o;
    logic wb_err_o;
    logic instr_ready_o;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    idx_decode idx_decode_i (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr), .instr_ready_o(instr_ready_o),
        .mem_o(mem_o), .mem_rdata_i(mem_rdata), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o));
    always #20 clk_i = ~clk_i;
    // =========================================================
    // shared tasks
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            stop_test;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_sel <= 4'hF;
        wb_adr <= a;
        wb_dat <= d;
        @(posedge clk_i iff (wb_ack_o === 1'b1 || wb_err_o === 1'b1));
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        wb_sel <= 4'h0;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        wb(1'b1, a, d, q, e);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic e;
        wb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk(32'(e), 32'(exp_err));
    endtask
    // one instruction: read cycle then optional write pulse
    task automatic exec(input logic [15:0] w, input logic [7:0] rd, input logic [11:0] ea, input logic wr,
                        input logic [7:0] wd);
        @(posedge clk_i);
        instr <= '{valid: 1'b1, word: w};
        mem_rdata <= rd;
        @(posedge clk_i);
        instr.valid <= 1'b0;
        #1;
        chk(32'({instr_ready_o, mem_o.req, mem_o.we, mem_o.addr}), 32'({3'b010, ea}));
        @(posedge clk_i);
        #1;
        chk(32'({mem_o.we, mem_o.addr}), 32'({wr, ea}));
        if (wr) begin
            chk(32'(mem_o.wdata), 32'(wd));
        end
    endtask
    // =========================================================
    // scenarios
    task automatic t_reset;
        rchk(CTRL_OFS, 32'h0, 1'b0);
        rchk(PTR_OFS, 32'h0, 1'b0);
        rchk(ACC_OFS, 32'h0, 1'b0);
        rchk(STATUS_OFS, 32'h0, 1'b0);
        rchk(8'h40, 32'h0, 1'b1);
    endtask
    task automatic t_add;
        wreg(CTRL_OFS, 32'h1);
        wreg(PTR_OFS, 32'hA00);
        wreg(ACC_OFS, 32'h17);
        exec(16'h242C, 8'h20, 12'hA2C, 1'b0, 8'h00);
        rchk(ACC_OFS, 32'h37, 1'b0);
        rchk(STATUS_OFS, 32'h00, 1'b0);
        rchk(PTR_OFS, 32'hA00, 1'b0);
        wreg(ACC_OFS, 32'h7F);
        exec(16'h2610, 8'h01, 12'hA10, 1'b1, 8'h80);
        rchk(ACC_OFS, 32'h7F, 1'b0);
        rchk(STATUS_OFS, 32'h1A, 1'b0);
        wreg(ACC_OFS, 32'h01);
        exec(16'h2400, 8'hFF, 12'hA00, 1'b0, 8'h00);
        rchk(ACC_OFS, 32'h00, 1'b0);
        rchk(STATUS_OFS, 32'h07, 1'b0);
    endtask
    task automatic t_bit_fill;
        for (int b = 0; b < 8; b++) begin
            exec({4'h8, 3'(b), 1'b0, 8'h0A}, 8'h55, 12'hA0A, 1'b1, 8'h55 | (8'h01 << b));
        end
        exec(16'h685F, 8'h00, 12'hA5F, 1'b1, FILL_VALUE);
        rchk(STATUS_OFS, 32'h07, 1'b0);
    endtask
    task automatic t_limits;
        exec(16'h6860, 8'h00, 12'h060, 1'b1, 8'hFF);
        wreg(BANK_OFS, 32'h3);
        exec(16'h692C, 8'h00, 12'h32C, 1'b1, 8'hFF);
        wreg(CTRL_OFS, 32'h0);
        exec(16'h682C, 8'h00, 12'h02C, 1'b1, 8'hFF);
        exec(16'h6890, 8'h00, 12'hF90, 1'b1, 8'hFF);
        rchk(CTRL_OFS, 32'h0, 1'b0);
        @(posedge clk_i);
        instr <= '{valid: 1'b1, word: 16'hF000};
        @(posedge clk_i);
        instr.valid <= 1'b0;
        #1;
        chk(32'({instr_ready_o, mem_o.req, mem_o.we}), 32'(3'b100));
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_add;
        t_bit_fill;
        t_limits;
        stop_test;
    end
endmodule // idx_decode_tb
`default_nettype wire

// file: verilog/idx_decode.sv
// Purpose: decode and execute of indexed add, bit set and fill on a data memory port
// Assumes: data memory answers reads combinationally; wishbone classic slave
// Notes:   one instruction per two clocks (read, then write)
// How it works
// - with the extension on, a low access-bank operand is an offset from the stack pointer register.
// - indexed add sums the accumulator and the byte at pointer plus k, k up to 95.
// - destination bit zero puts the sum in the accumulator, one writes it back to memory.
// - indexed add updates negative, overflow, carry, digit carry and zero flags.
// - indexed add is upper byte 0010 01d0 with the offset in the lower byte.
// - indexed bit set sets bit b of the byte at pointer plus k, upper byte 1000 bbb0, no flags.
// - indexed fill, upper byte 0110 1000, writes FFh at pointer plus k, no flags.
// - the extension config bit clear disables indexed addressing only; add, bit set and fill still execute on absolute addresses.
// - without indexing, select bit zero is the access bank and one is the bank register bank.
// - indexing needs extension on, select bit zero and operand at most 5Fh.
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module idx_decode (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire idx_decode_pkg::instr_s     instr_i,
    output logic                            instr_ready_o,
    output var idx_decode_pkg::mem_req_s    mem_o,
    input  wire logic [7:0]                 mem_rdata_i,
    input  wire logic [7:0]                 wb_adr_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic [31:0]                     wb_dat_o,
    input  wire logic                       wb_we_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    output logic                            wb_ack_o,
    output logic                            wb_err_o
);
    import idx_decode_pkg::*;

    typedef enum logic [0:0] {ST_FETCH, ST_WRITE} state_e;

    state_e              state_reg;
    logic                ext_reg;
    logic [ADDR_W-1:0]   ptr_reg;
    logic [3:0]          bank_reg;
    logic [7:0]          acc_reg;
    logic [4:0]          status_reg;
    logic [15:0]         op_reg;
    logic [ADDR_W-1:0]   addr_reg;
    logic [7:0]          wdata_reg;
    logic                wr_reg;
    logic                ack_reg;
    wire        wb_req  = wb_cyc_i && wb_stb_i && !ack_reg;
    wire        wb_wr   = wb_req && wb_we_i;
    wire        hit     = (wb_adr_i == CTRL_OFS) || (wb_adr_i == PTR_OFS) || (wb_adr_i == BANK_OFS)
                        || (wb_adr_i == ACC_OFS) || (wb_adr_i == STATUS_OFS);

    // ======== decode
    wire [7:0]  hi        = instr_i.word[15:8];
    wire [7:0]  lo        = instr_i.word[7:0];
    wire        is_add    = (hi & OPC_ADD_MASK) == OPC_ADD_VAL;
    // bit set and fill decode for either bank select
    wire [7:0]  hi_dir    = {hi[7:1], 1'b0};
    wire        is_bit    = (hi_dir & OPC_BIT_MASK) == OPC_BIT_VAL;
    wire        is_fill   = hi_dir == OPC_FILL_VAL;
    wire        acc_sel   = hi[0];
    wire        indexed   = ext_reg && !acc_sel && (lo <= INDEX_LIMIT);
    wire [ADDR_W-1:0] idx_addr = ptr_reg + {{(ADDR_W-8){1'b0}}, lo};
    wire [ADDR_W-1:0] abs_addr = acc_sel ? {bank_reg, lo}
                               : (lo[7] ? {4'hF, lo} : {4'h0, lo});
    wire [ADDR_W-1:0] eff_addr = indexed ? idx_addr : abs_addr;
    wire        accept    = instr_i.valid && (state_reg == ST_FETCH);

    // ======== execute
    wire [7:0]  rd        = mem_rdata_i;
    wire [8:0]  sum       = {1'b0, acc_reg} + {1'b0, rd};
    wire [4:0]  nib       = {1'b0, acc_reg[3:0]} + {1'b0, rd[3:0]};
    wire        ovf       = (acc_reg[7] == rd[7]) && (sum[7] != rd[7]);
    wire [2:0]  bsel      = op_reg[BIT_SEL_LSB+10:BIT_SEL_LSB+8];
    wire        op_add    = (op_reg[15:8] & OPC_ADD_MASK) == OPC_ADD_VAL;
    wire        op_bit    = ({op_reg[15:9], 1'b0} & OPC_BIT_MASK) == OPC_BIT_VAL;
    wire        dest_mem  = op_reg[DEST_BIT+8];
    wire [7:0]  bit_res   = rd | (8'h01 << bsel);
    wire [7:0]  exe_data  = op_add ? sum[7:0] : (op_bit ? bit_res : FILL_VALUE);
    wire        exe_wr    = !(op_add && !dest_mem);
    wire [4:0]  add_flags = {sum[7], ovf, sum[7:0] == 8'h00, nib[4], sum[8]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_FETCH;
            op_reg    <= 16'h0000;
            addr_reg  <= '0;
            wdata_reg <= 8'h00;
            wr_reg    <= 1'b0;
            acc_reg   <= ACC_RST;
            status_reg <= STATUS_RST;
        end else begin
            wr_reg <= 1'b0;
            case (state_reg)
                ST_FETCH: begin
                    if (accept && (is_add || is_bit || is_fill)) begin
                        op_reg    <= instr_i.word;
                        addr_reg  <= eff_addr;
                        state_reg <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    wdata_reg <= exe_data;
                    wr_reg    <= exe_wr;
                    if (op_add) begin
                        status_reg <= add_flags;
                        if (!dest_mem) begin
                            acc_reg <= sum[7:0];
                        end
                    end
                    state_reg <= ST_FETCH;
                end
                default: state_reg <= ST_FETCH;
            endcase
            if (wb_wr && wb_adr_i == ACC_OFS && wb_sel_i[0]) begin
                acc_reg <= wb_dat_i[7:0];
            end
            if (wb_wr && wb_adr_i == STATUS_OFS && wb_sel_i[0]) begin
                status_reg <= wb_dat_i[4:0];
            end
        end
    end

    assign instr_ready_o = state_reg == ST_FETCH;
    assign mem_o.req     = (state_reg == ST_WRITE) || wr_reg;
    assign mem_o.we      = wr_reg;
    assign mem_o.addr    = addr_reg;
    assign mem_o.wdata   = wdata_reg;

    // ======== wishbone slave
    logic [31:0] rd_mux;
    logic        err_reg;

    always_comb begin
        case (wb_adr_i)
            CTRL_OFS:   rd_mux = {31'h0, ext_reg};
            PTR_OFS:    rd_mux = {20'h0, ptr_reg};
            BANK_OFS:   rd_mux = {28'h0, bank_reg};
            ACC_OFS:    rd_mux = {24'h0, acc_reg};
            STATUS_OFS: rd_mux = {27'h0, status_reg};
            default:    rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_reg  <= EXT_RST;
            ptr_reg  <= PTR_RST;
            bank_reg <= BANK_RST;
            ack_reg  <= 1'b0;
            err_reg  <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_reg  <= wb_req && hit;
            err_reg  <= wb_req && !hit;
            wb_dat_o <= rd_mux;
            if (wb_wr && wb_sel_i[0]) begin
                if (wb_adr_i == CTRL_OFS) ext_reg <= wb_dat_i[0];
                if (wb_adr_i == BANK_OFS) bank_reg <= wb_dat_i[3:0];
                if (wb_adr_i == PTR_OFS)  ptr_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_wr && wb_sel_i[1] && wb_adr_i == PTR_OFS) begin
                ptr_reg[11:8] <= wb_dat_i[11:8];
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;

    // ======== assertions
    AST_IDX_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
        accept && is_fill && ext_reg && !acc_sel && lo <= INDEX_LIMIT |=> mem_o.addr == $past(ptr_reg) + 12'($past(lo)))
        else $error("indexed address wrong");
    AST_NO_IDX_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        accept && is_fill && !ext_reg && !acc_sel |=> mem_o.addr == {{4{$past(lo[7])}}, $past(lo)})
        else $error("indexing while extension off");
    AST_BANK: assert property (@(posedge clk_i) disable iff (rst_i)
        accept && (is_bit || is_fill) && acc_sel |=> mem_o.addr[11:8] == $past(bank_reg))
        else $error("bank select not used");
    AST_HIGH_OP: assert property (@(posedge clk_i) disable iff (rst_i)
        accept && is_fill && !acc_sel && lo > INDEX_LIMIT |=> mem_o.addr == {{4{$past(lo[7])}}, $past(lo)})
        else $error("high operand indexed");
    AST_FILL: assert property (@(posedge clk_i) disable iff (rst_i)
        accept && is_fill |=> ##1 mem_o.we && mem_o.wdata == FILL_VALUE && $stable(status_reg))
        else $error("fill wrong");
    AST_ADD_W: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_WRITE && op_add && !dest_mem && !wb_wr |=> acc_reg == $past(sum[7:0]) && !mem_o.we)
        else $error("add to accumulator wrong");
    AST_ADD_M: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_WRITE && op_add && dest_mem |=> mem_o.we && mem_o.wdata == $past(sum[7:0]))
        else $error("add to memory wrong");
    AST_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_WRITE && op_add && !wb_wr |=> status_reg[FLAG_Z] == ($past(sum[7:0]) == 8'h00)
        && status_reg[FLAG_C] == $past(sum[8]))
        else $error("add flags wrong");
    AST_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_WRITE && op_bit |=> mem_o.wdata[$past(bsel)] && $stable(status_reg))
        else $error("bit set wrong");
    AST_PTR: assert property (@(posedge clk_i) disable iff (rst_i)
        accept && !wb_wr |=> $stable(ptr_reg))
        else $error("pointer changed");
    AST_DECODE: assert property (@(posedge clk_i) disable iff (rst_i)
        accept && !(is_add || is_bit || is_fill) |=> state_reg == ST_FETCH)
        else $error("unknown opcode taken");
endmodule // idx_decode
`default_nettype wire

// file: verilog/idx_decode_pkg.sv
// Purpose: shared constants and carriers for the indexed offset operand decoder
// Assumes: 12-bit data address, 8-bit data
// Notes:   register offsets are word aligned byte addresses on the bus
`default_nettype none
package idx_decode_pkg;
    localparam int          ADDR_W          = 12;
    localparam logic [7:0]  INDEX_LIMIT     = 8'h5F;
    localparam logic [7:0]  FILL_VALUE      = 8'hFF;
    // opcode upper byte patterns
    localparam logic [7:0]  OPC_ADD_MASK    = 8'hFD;
    localparam logic [7:0]  OPC_ADD_VAL     = 8'h24;
    localparam logic [7:0]  OPC_BIT_MASK    = 8'hF1;
    localparam logic [7:0]  OPC_BIT_VAL     = 8'h80;
    localparam logic [7:0]  OPC_FILL_VAL    = 8'h68;
    localparam int          DEST_BIT        = 1;
    localparam int          BIT_SEL_LSB     = 1;
    // register offsets
    localparam logic [7:0]  CTRL_OFS        = 8'h00;
    localparam logic [7:0]  PTR_OFS         = 8'h04;
    localparam logic [7:0]  BANK_OFS        = 8'h08;
    localparam logic [7:0]  ACC_OFS         = 8'h0C;
    localparam logic [7:0]  STATUS_OFS      = 8'h10;
    // status field positions
    localparam int          FLAG_C          = 0;
    localparam int          FLAG_DC         = 1;
    localparam int          FLAG_Z          = 2;
    localparam int          FLAG_OV         = 3;
    localparam int          FLAG_N          = 4;
    // reset values
    localparam logic        EXT_RST         = 1'b0;
    localparam logic [11:0] PTR_RST         = 12'h000;
    localparam logic [3:0]  BANK_RST        = 4'h0;
    localparam logic [7:0]  ACC_RST         = 8'h00;
    localparam logic [4:0]  STATUS_RST      = 5'h00;

    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } instr_s;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } mem_req_s;
endpackage
`default_nettype wire
